// [design/tcl_loader.sv]
// Serial configuration loader and operating-mode sequencer of the transmitter.
// Assumes enable, data, serial clock and osc ready arrive asynchronously to clk,
// and that osc_tick pulses once per crystal cycle from logic on clk.
`timescale 1ns/1ps
`default_nettype none
`include "tcl_consts.svh"
// Notes on behaviour
// - Bit 31 high selects clock-only mode, low normal transmit.
// - Bit 30 selects upper oscillator band when high, lower when low.
// - Bits 29 to 15 hold the 15-bit carrier word.
// - Bits 14 to 7 hold the 8-bit FSK deviation word.
// - Bit 6 picks clock divider: 8 when low, 4 when high.
// - Bits 5 to 2 hold the amplifier level, applied to the amplifier.
// - Bit 1 selects FSK when low, ASK when high.
// - Bit 0 switches the clock output driver on.
// - Word arrives MSB first on the shared data pin.
// - Data is sampled on each rising serial clock edge.
// - Word is committed on the falling edge of the last bit.
// - After 32 bits the data pin is modulation; serial clock ignored.
// - Enable and data both low turns everything off.
// - Reload state keeps amplifier and PLL off, oscillator running.
// - After reload, enable, clock and data low return to off.
// - Config mode with clock-only low starts PLL on falling edge of bit 30.
// - After commit with osc ready, go clock-only or second start-up.
// - Lock 1280 crystal cycles after commit; then transmit with or without amp.
// - Per-state enables of oscillator, PLL, clock driver and amplifier.
// - Clock driver runs only while the clock output enable bit is set.
module tcl_loader #(
  parameter int lock_cycles = `TCL_LOCK_CYCLES,
  parameter int reload_min_cycles = `TCL_RELOAD_MIN_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic enable_pin,
  input wire logic serial_data_mod_input,
  input wire logic serial_clk_pin,
  input wire logic osc_ready_flag,
  input wire logic osc_tick,
  output logic [`TCL_WORD_BITS-1:0] transmitter_config_word,
  output tcl_pkg::tcl_mode_type mode,
  output logic crystal_osc_on,
  output logic pll_on,
  output logic clock_out_driver,
  output logic pa_on,
  output logic [`TCL_PA_MSB-`TCL_PA_LSB:0] pa_level_field,
  output logic [`TCL_CARRIER_WORD_A_MSB-`TCL_CARRIER_WORD_A_LSB:0] carrier_word_a,
  output logic [`TCL_DEV_MSB-`TCL_DEV_LSB:0] fsk_deviation_word,
  output logic vco_band_select,
  output logic clkout_divider_select,
  output logic modulation_select,
  output logic tx_mod_data,
  output logic pll_locked
);
  import tcl_pkg::*;

  // Two-stage synchronisers; stage one is read only by stage two
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sck_prev;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sck_prev <= 1'b0;
    end else if (clk_en) begin
      sync1 <= {osc_ready_flag, serial_clk_pin, serial_data_mod_input, enable_pin};
      sync2 <= sync1;
      sck_prev <= sync2[2];
    end
  end

  wire en_s = sync2[0];
  wire data_s = sync2[1];
  wire sck_s = sync2[2];
  wire rdy_s = sync2[3];
  // sck_prev resets low like the idle pin, so reset release makes no false edge
  wire sck_rise = sck_s & ~sck_prev;
  wire sck_fall = ~sck_s & sck_prev;

  // Shift register and bit counter; counter saturates at 32
  tcl_word_type shift;
  logic [5:0] bit_cnt;
  logic done;
  wire loading = en_s & ~done;
  wire [5:0] full_cnt = 6'(`TCL_WORD_BITS);
  wire take_bit = loading & sck_rise & (bit_cnt != full_cnt);
  wire last_fall = loading & sck_fall & (bit_cnt == full_cnt);
  // Bit 30 is the second one shifted in
  wire partial_fall = loading & sck_fall & (bit_cnt == 6'h02);
  wire [5:0] next_bit_cnt = bit_cnt + 6'h01;
  tcl_word_type next_shift;
  assign next_shift = {shift[`TCL_WORD_BITS-2:0], data_s};

  // Bit counter; enable low discards a partial word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= 6'h00;
    end else if (clk_en) begin
      if (!en_s) begin
        bit_cnt <= 6'h00;
      end else if (take_bit) begin
        bit_cnt <= next_bit_cnt;
      end
    end
  end

  // Shift register keeps its bits over enable low; only the count is cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift <= `TCL_CFG_RESET;
    end else if (clk_en && take_bit) begin
      shift <= next_shift;
    end
  end

  // Word-done flag; set and clear never meet, as loading needs enable high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (clk_en) begin
      if (!en_s) begin
        done <= 1'b0;
      end else if (last_fall) begin
        done <= 1'b1;
      end
    end
  end

  // Committed word and its fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmitter_config_word <= `TCL_CFG_RESET;
    end else if (clk_en && last_fall) begin
      transmitter_config_word <= shift;
    end
  end

  wire cfg_clk_only = transmitter_config_word[`TCL_BIT_CLK_ONLY];
  wire cfg_ask = transmitter_config_word[`TCL_BIT_MOD];
  wire cfg_clkout = transmitter_config_word[`TCL_BIT_CLKOUT_EN];
  // The bit already shifted for bit 31 is at shift[1] when bit 30 arrives
  wire part_clk_only = shift[1];

  // Lock counter of crystal cycles after commit with oscillator ready
  logic [10:0] lock_cnt;
  logic commit_seen;
  wire [10:0] lock_last = 11'(lock_cycles);
  wire lock_step = commit_seen & rdy_s & osc_tick & ~pll_locked;
  wire lock_hit = lock_step & (lock_cnt == lock_last - 11'h001);

  // Commit marker arms the lock count; enable low drops it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      commit_seen <= 1'b0;
    end else if (clk_en) begin
      if (!en_s) begin
        commit_seen <= 1'b0;
      end else if (last_fall) begin
        commit_seen <= 1'b1;
      end
    end
  end

  // Crystal cycles after commit; a new commit restarts the count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_cnt <= 11'h000;
    end else if (clk_en) begin
      if (!en_s || last_fall) begin
        lock_cnt <= 11'h000;
      end else if (lock_step) begin
        lock_cnt <= lock_cnt + 11'h001;
      end
    end
  end

  // Lock falls on a new commit so a changed word must relock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_locked <= 1'b0;
    end else if (clk_en) begin
      if (!en_s || last_fall) begin
        pll_locked <= 1'b0;
      end else if (lock_hit) begin
        pll_locked <= 1'b1;
      end
    end
  end

  // Reload entry needs data high with enable low for the minimum time
  logic [7:0] reload_cnt;
  wire [7:0] reload_last = 8'(reload_min_cycles);
  wire reload_req = ~en_s & data_s;
  wire reload_ok = reload_req & (reload_cnt >= reload_last);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_cnt <= 8'h00;
    end else if (clk_en) begin
      if (!reload_req) begin
        reload_cnt <= 8'h00;
      end else if (!reload_ok) begin
        reload_cnt <= reload_cnt + 8'h01;
      end
    end
  end

  // Operating-mode sequencer
  tcl_mode_type next_mode;
  wire all_low = ~en_s & ~data_s;
  wire go_tx = pll_locked;
  // ASK re-picks amplifier on or off from the data pin on every cycle
  wire tx_amp = ~cfg_ask | data_s;
  tcl_mode_type tx_next;
  assign tx_next = tx_amp ? TCL_TX_AMP : TCL_TX_NO_AMP;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      TCL_OFF: if (en_s) next_mode = TCL_START1;
      TCL_START1: begin
        if (all_low) next_mode = TCL_OFF;
        else if (done && rdy_s) next_mode = cfg_clk_only ? TCL_CLK_ONLY : TCL_START2;
      end
      TCL_START2: begin
        if (all_low) next_mode = TCL_OFF;
        else if (go_tx) next_mode = tx_next;
      end
      TCL_TX_NO_AMP, TCL_TX_AMP, TCL_CLK_ONLY: begin
        if (all_low) next_mode = TCL_OFF;
        else if (reload_ok) next_mode = TCL_RELOAD;
        else if (mode != TCL_CLK_ONLY) next_mode = tx_next;
      end
      TCL_RELOAD: begin
        if (all_low) next_mode = TCL_OFF;
        else if (en_s) next_mode = TCL_CONFIG1;
      end
      TCL_CONFIG1: begin
        if (all_low && !sck_s) next_mode = TCL_OFF;
        else if (reload_ok) next_mode = TCL_RELOAD;
        else if (last_fall && shift[`TCL_BIT_CLK_ONLY]) next_mode = TCL_CLK_ONLY;
        else if (partial_fall && !part_clk_only) next_mode = TCL_CONFIG2;
      end
      TCL_CONFIG2: begin
        if (all_low && !sck_s) next_mode = TCL_OFF;
        else if (reload_ok) next_mode = TCL_RELOAD;
        else if (done && go_tx) next_mode = tx_next;
      end
      default: next_mode = TCL_OFF;
    endcase
  end

  // Per-mode block enables
  wire mode_osc = (mode != TCL_OFF);
  wire mode_pll = (mode == TCL_START2) | (mode == TCL_TX_NO_AMP) | (mode == TCL_TX_AMP) |
                  (mode == TCL_CONFIG2);
  // Clock driver may run in these modes; the enable bit gates it at the output flop
  wire mode_drv = (mode == TCL_TX_NO_AMP) | (mode == TCL_TX_AMP) | (mode == TCL_CLK_ONLY) |
                  (mode == TCL_RELOAD) | (mode == TCL_CONFIG1) | (mode == TCL_CONFIG2);
  wire mode_pa = (mode == TCL_TX_AMP);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= TCL_OFF;
      crystal_osc_on <= 1'b0;
      pll_on <= 1'b0;
      clock_out_driver <= 1'b0;
      pa_on <= 1'b0;
      tx_mod_data <= 1'b0;
    end else if (clk_en) begin
      mode <= next_mode;
      crystal_osc_on <= mode_osc;
      pll_on <= mode_pll;
      clock_out_driver <= mode_drv & cfg_clkout;
      pa_on <= mode_pa;
      tx_mod_data <= done & data_s;
    end
  end

  // Field outputs mirror the committed word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pa_level_field <= 4'h0;
      carrier_word_a <= 15'h0000;
      fsk_deviation_word <= 8'h00;
      vco_band_select <= 1'b0;
      clkout_divider_select <= 1'b0;
      modulation_select <= 1'b0;
    end else if (clk_en) begin
      pa_level_field <= transmitter_config_word[`TCL_PA_MSB:`TCL_PA_LSB];
      carrier_word_a <= transmitter_config_word[`TCL_CARRIER_WORD_A_MSB:`TCL_CARRIER_WORD_A_LSB];
      fsk_deviation_word <= transmitter_config_word[`TCL_DEV_MSB:`TCL_DEV_LSB];
      vco_band_select <= transmitter_config_word[`TCL_BIT_BAND];
      clkout_divider_select <= transmitter_config_word[`TCL_BIT_DIV];
      modulation_select <= cfg_ask;
    end
  end
endmodule
`default_nettype wire

// [design/tcl_consts.svh]
// Constants for the transmitter configuration loader: field positions, counts, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH
`define TCL_WORD_BITS 32
`define TCL_BIT_CLK_ONLY 31
`define TCL_BIT_BAND 30
`define TCL_CARRIER_WORD_A_MSB 29
`define TCL_CARRIER_WORD_A_LSB 15
`define TCL_DEV_MSB 14
`define TCL_DEV_LSB 7
`define TCL_BIT_DIV 6
`define TCL_PA_MSB 5
`define TCL_PA_LSB 2
`define TCL_BIT_MOD 1
`define TCL_BIT_CLKOUT_EN 0
`define TCL_CFG_RESET 32'h0000_0000
`define TCL_LOCK_CYCLES 1280
`define TCL_RELOAD_MIN_US 10
`define TCL_CLK_MHZ 10
`define TCL_RELOAD_MIN_CYC ((`TCL_RELOAD_MIN_US * `TCL_CLK_MHZ))
`endif

// [design/tcl_pkg.sv]
// Types for the transmitter configuration loader.
// Assumes the constants header is on the include path.
`include "tcl_consts.svh"
package tcl_pkg;
  typedef enum logic [3:0] {
    TCL_OFF = 4'b0000,
    TCL_START1 = 4'b0001,
    TCL_START2 = 4'b0010,
    TCL_TX_NO_AMP = 4'b0011,
    TCL_TX_AMP = 4'b0100,
    TCL_CLK_ONLY = 4'b0101,
    TCL_RELOAD = 4'b0110,
    TCL_CONFIG1 = 4'b0111,
    TCL_CONFIG2 = 4'b1000
  } tcl_mode_type;
  typedef logic [`TCL_WORD_BITS-1:0] tcl_word_type;
endpackage

// [verif/tcl_loader_props.sv]
// Checker for the configuration loader's port behaviour.
// Assumes binding to tcl_loader; one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "tcl_consts.svh"
module tcl_loader_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_pin,
  input wire logic serial_data_mod_input,
  input wire logic [`TCL_WORD_BITS-1:0] transmitter_config_word,
  input wire tcl_pkg::tcl_mode_type mode,
  input wire logic crystal_osc_on,
  input wire logic pll_on,
  input wire logic clock_out_driver,
  input wire logic pa_on,
  input wire logic [`TCL_PA_MSB-`TCL_PA_LSB:0] pa_level_field,
  input wire logic modulation_select
);
  import tcl_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Pins must settle past the synchroniser before off is owed
  sequence s_off_pins;
    (!enable_pin && !serial_data_mod_input) [*6];
  endsequence
  a_off_quiet: assert property (mode == TCL_OFF |=> !(crystal_osc_on || pll_on ||
    clock_out_driver || pa_on)) else $error("block enabled while off");
  a_start1_osc: assert property (mode == TCL_START1 |=> crystal_osc_on && !pll_on && !pa_on)
    else $error("wrong enables in first start-up");
  a_amp_only_tx: assert property (pa_on |-> $past(mode) == TCL_TX_AMP)
    else $error("amplifier on outside transmit with amplifier");
  a_pll_states: assert property (pll_on |-> $past(mode) inside
    {TCL_START2, TCL_TX_NO_AMP, TCL_TX_AMP, TCL_CONFIG2}) else $error("pll on in wrong state");
  a_reload_pa_off: assert property (mode == TCL_RELOAD |=> crystal_osc_on && !pll_on && !pa_on)
    else $error("reload state enables wrong");
  a_clkdrv_gate: assert property (clock_out_driver |->
    $past(transmitter_config_word[0])) else $error("clock driver without enable bit");
  a_fields_follow: assert property ($stable(transmitter_config_word) [*3] |->
    pa_level_field == transmitter_config_word[5:2] && modulation_select == transmitter_config_word[1])
    else $error("fields differ from committed word");
  a_off_entry: assert property (s_off_pins |-> ##[0:3] mode == TCL_OFF)
    else $error("pins low but not off");
endmodule
`default_nettype wire

// [verif/tcl_host_model.sv]
// Host controller model driving enable, data and serial clock.
// Assumes tasks are called from the bench; drives 10 ns after clk rises.
`timescale 1ns/1ps
`default_nettype none
module tcl_host_model (
  input wire logic clk,
  output logic enable_pin,
  output logic serial_data_mod_input,
  output logic serial_clk_pin
);
  initial begin
    enable_pin = 1'b0;
    serial_data_mod_input = 1'b0;
    serial_clk_pin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic pins(input logic en, input logic d);
    tick(1);
    enable_pin = en;
    serial_data_mod_input = d;
  endtask
  // MSB first; sck high 500 ns and low 600 ns per bit (1.1 us period), idle low between frames
  task automatic send(input logic [31:0] w, input int n);
    for (int i = 31; i > 31 - n; i--) begin
      tick(1);
      serial_data_mod_input = w[i];
      tick(5);
      serial_clk_pin = 1'b1;
      tick(5);
      serial_clk_pin = 1'b0;
    end
    tick(1);
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the configuration loader and mode sequencer.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "tcl_consts.svh"
module tb;
  import tcl_pkg::*;
  logic clk, rst_n, clk_en, osc_ready_flag, osc_tick;
  wire logic enable_pin, serial_data_mod_input, serial_clk_pin;
  tcl_word_type transmitter_config_word;
  tcl_mode_type mode;
  logic crystal_osc_on, pll_on, clock_out_driver, pa_on, vco_band_select;
  logic clkout_divider_select, modulation_select, tx_mod_data, pll_locked;
  logic [3:0] pa_level_field;
  logic [14:0] carrier_word_a;
  logic [7:0] fsk_deviation_word;
  int miscompares = 0;
  int n_tests = 0;
  localparam tcl_word_type w_fsk = {2'b01, 15'h1a2b, 8'hc5, 1'b1, 4'ha, 2'b01};
  localparam tcl_word_type w_ask = {2'b00, 15'h7fff, 8'hff, 1'b0, 4'hf, 2'b10};
  localparam tcl_word_type w_clk = {2'b11, 15'h0001, 8'h01, 1'b0, 4'h0, 2'b11};
  tcl_loader #(.lock_cycles(8), .reload_min_cycles(4)) tcl_loader_inst (.clk, .rst_n,
    .clk_en, .enable_pin, .serial_data_mod_input, .serial_clk_pin, .osc_ready_flag,
    .osc_tick, .transmitter_config_word, .mode, .crystal_osc_on, .pll_on,
    .clock_out_driver, .pa_on, .pa_level_field, .carrier_word_a, .fsk_deviation_word,
    .vco_band_select, .clkout_divider_select, .modulation_select, .tx_mod_data, .pll_locked);
  tcl_host_model host (.clk, .enable_pin, .serial_data_mod_input, .serial_clk_pin);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Crystal ticks every other cycle so the lock count is not one-per-clk
  always @(posedge clk) #10 osc_tick = ~osc_tick;
  task automatic end_sim;
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_mode(input tcl_mode_type m);
    int i = 0;
    while (mode !== m && i < 300) begin
      host.tick(1);
      i++;
    end
    chk(32'(mode), 32'(m));
  endtask
  task automatic chk_cfg(input tcl_word_type w);
    chk(transmitter_config_word, w);
    chk(32'({vco_band_select, carrier_word_a, fsk_deviation_word, clkout_divider_select,
      pa_level_field, modulation_select}), 32'(w[30:1]));
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    osc_ready_flag = 1'b0;
    osc_tick = 1'b0;
    repeat (16) @(posedge clk);
    #10;
    rst_n = 1'b1;
    // Oscillator stays unready over the first commit
    host.pins(1'b1, 1'b0);
    wait_mode(TCL_START1);
    host.send(w_fsk, 31);
    host.pins(1'b0, 1'b0);
    host.tick(10);
    chk(transmitter_config_word, 32'h0000_0000);
    host.pins(1'b1, 1'b0);
    host.send(w_fsk, 32);
    host.tick(8);
    chk(32'(mode), 32'(TCL_START1));
    osc_ready_flag = 1'b1;
    wait_mode(TCL_START2);
    host.tick(2);
    chk_cfg(w_fsk);
    wait_mode(TCL_TX_AMP);
    host.tick(2);
    chk(32'({pa_on, clock_out_driver, pll_locked}), 32'h7);
    host.send(32'h0000_0000, 4);
    host.pins(1'b1, 1'b1);
    host.tick(5);
    chk(transmitter_config_word, w_fsk);
    chk(32'(tx_mod_data), 32'h1);
    // A data change while clk_en is low must not reach the outputs
    clk_en = 1'b0;
    host.pins(1'b1, 1'b0);
    host.tick(4);
    chk(32'({tx_mod_data, pa_on}), 32'h3);
    clk_en = 1'b1;
    host.tick(5);
    chk(32'({tx_mod_data, pa_on}), 32'h1);
    host.pins(1'b0, 1'b0);
    wait_mode(TCL_OFF);
    host.pins(1'b1, 1'b0);
    host.send(w_ask, 32);
    wait_mode(TCL_TX_NO_AMP);
    host.tick(2);
    chk(32'({pa_on, clock_out_driver}), 32'h0);
    host.pins(1'b1, 1'b1);
    wait_mode(TCL_TX_AMP);
    host.pins(1'b0, 1'b1);
    host.tick(6);
    wait_mode(TCL_RELOAD);
    host.pins(1'b1, 1'b1);
    host.tick(4);
    host.send(w_clk, 32);
    wait_mode(TCL_CLK_ONLY);
    host.tick(2);
    chk(32'({pll_on, crystal_osc_on, clock_out_driver}), 32'h3);
    host.pins(1'b0, 1'b1);
    host.tick(6);
    wait_mode(TCL_RELOAD);
    host.pins(1'b1, 1'b1);
    host.tick(4);
    host.send(w_fsk, 32);
    wait_mode(TCL_CONFIG2);
    chk(32'({pll_on, pa_on}), 32'h2);
    wait_mode(TCL_TX_AMP);
    chk(transmitter_config_word, w_fsk);
    host.pins(1'b0, 1'b0);
    wait_mode(TCL_OFF);
    host.pins(1'b1, 1'b0);
    wait_mode(TCL_START1);
    rst_n = 1'b0;
    host.tick(2);
    rst_n = 1'b1;
    host.tick(1);
    chk(32'({mode, crystal_osc_on}), 32'h0);
    chk(transmitter_config_word, `TCL_CFG_RESET);
    wait_mode(TCL_START1);
    host.pins(1'b0, 1'b0);
    wait_mode(TCL_OFF);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule
bind tcl_loader tcl_loader_props tcl_loader_props_inst (.clk, .rst_n, .enable_pin,
  .serial_data_mod_input, .transmitter_config_word, .mode, .crystal_osc_on, .pll_on,
  .clock_out_driver, .pa_on, .pa_level_field, .modulation_select);
`default_nettype wire
